// ==== dpll_ctrl_core.sv ====
`timescale 1ns/1ns
`include "dpll_ctrl_regs.svh"
// Functional notes
// - Shift data in on serial clock rise
// - Word arrives MSB first, bit 21 first
// - Latch enable rise loads one latch
// - Destination from word bits 1 and 0
// - Select 00/01/10/11 picks latch
// - Loop-two reference latch field layout
// - Loop-one counter latch field layout
// - 14-bit reference, 17-bit feedback divider
// - Four select bits steer status output
// - Lock shows high with low pulses
// - Combined lock needs both loops locked
// - Counter reset holds counters, pump off
// - Counters restart aligned after reset release
// - Loop-one gain set drives fastlock output
// - Power-down with pump on: pump first
// - Power-down with pump off: immediate
// - Power-down loads dividers, debiases input
// - Oscillator off only when both down
// - Writes keep working during power-down
// - Clearing power-down resumes loop at once
// - Comparator adds short antibacklash pulse
// - Bit 20 picks prescaler modulus
// - Pump three-state bit sets high impedance
module dpll_ctrl_core
  import dpll_pkg::*;
#(
  parameter int LOCK_CMP = 15 // Clean comparisons to show lock
) (
  input  wire logic       clock,        // 100 MHz clock
  input  wire logic       sys_rst,      // Sync reset, high
  input  wire logic       serial_clk,   // Serial clock pin
  input  wire logic       serial_data,  // Serial data pin
  input  wire logic       latch_strobe, // Latch enable pin
  input  wire logic       ref_in,       // Reference oscillator pin
  input  wire logic [1:0] rf_in,        // Prescaler inputs, [1] one
  output logic [1:0]      pump_up,      // Pump source, [1] one
  output logic [1:0]      pump_dn,      // Pump sink, [1] one
  output logic [1:0]      pump_hiz,     // Pump high impedance
  output logic [1:0]      pump_gain_hi, // Pump high current
  output logic [1:0]      input_debias, // RF input powered down
  output logic            ref_osc_en,   // Reference oscillator on
  output logic            status_select_output,    // Pin level
  output logic            status_select_output_oe  // Pull-down on
);
  // Lock counter is eight bits wide
  if (LOCK_CMP < 1 || LOCK_CMP > 255) begin : g_bad_lock
    $error("dpll_ctrl_core: LOCK_CMP out of range");
  end

  localparam logic [7:0] LK_MAX = 8'(LOCK_CMP); // Lock threshold
  localparam logic [1:0] ABL    = 2'(`ABL_CYC); // Overlap cycles

  // Pin synchroniser
  pin_sync_if ps ();

  pin_sync #(
    .N (`PIN_N)
  ) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pins    ({rf_in, ref_in, latch_strobe, serial_data,
               serial_clk}),
    .ps      (ps)
  );

  // Shift register and the four latches
  word_t sh_q, sh_d;     // Input shift register
  word_t lat_q [4];      // Destination latches
  word_t lat_d [4];      // Next latch contents

  // Next shift and latch values
  always_comb begin
    sh_d = sh_q;
    for (int k = 0; k < 4; k++) begin
      lat_d[k] = lat_q[k];
    end
    // New bit enters at the bottom, first bit ends at the top
    if (ps.rise[`PIN_SCLK]) begin
      sh_d = {sh_q[`WORD_W-2:0], ps.level[`PIN_SDATA]};
    end
    // Loads go on in every power-down mode
    if (ps.rise[`PIN_LE]) begin
      lat_d[sh_q[`SEL_HI:`SEL_LO]] = sh_q;
    end
  end

  // Register shift and latches
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sh_q <= '0;
      for (int k = 0; k < 4; k++) begin
        lat_q[k] <= '0;
      end
    end else begin
      sh_q <= sh_d;
      for (int k = 0; k < 4; k++) begin
        lat_q[k] <= lat_d[k];
      end
    end
  end

  // Fields per loop, index 0 loop two, 1 loop one
  logic [1:0] pd_bit;    // Power-down bit
  logic [1:0] hiz_bit;   // Pump three-state bit
  logic [1:0] gain_bit;  // Pump gain bit
  logic [1:0] pol_bit;   // Detector polarity bit
  logic [1:0] mod_bit;   // Prescaler modulus bit
  logic [1:0] crst;      // Counter reset from status select
  rdiv_t      rdiv [2];  // Reference divide value
  bcnt_t      bval [2];  // Main count
  acnt_t      aval [2];  // Swallow count
  logic [`MUX_W-1:0] mux_sel; // Status select
  logic       fastlock;  // Fastlock active

  // Per-loop state seen by the status mux and the pump and debias outputs
  logic [1:0] locked;    // Loop locked
  logic [1:0] up;        // Raw comparator up
  logic [1:0] dn;        // Raw comparator down
  logic [1:0] rtick;     // Divided reference pulse
  logic [1:0] ftick;     // Divided feedback pulse
  logic [1:0] hiz;       // Pump off for any reason
  logic [1:0] pwr_dn;    // Loop powered down

  for (genvar i = 0; i < 2; i++) begin : g_fld
    localparam int RI = 2 * i;     // Reference latch index
    localparam int CI = 2 * i + 1; // Counter latch index
    assign hiz_bit[i]  = lat_q[RI][`REF_HIZ];
    assign gain_bit[i] = lat_q[RI][`REF_GAIN];
    assign pol_bit[i]  = lat_q[RI][`REF_POL];
    assign rdiv[i]     = lat_q[RI][`REF_R_MSB:`REF_R_LSB];
    assign pd_bit[i]   = lat_q[CI][`CNT_PD];
    assign mod_bit[i]  = lat_q[CI][`CNT_MOD];
    assign bval[i]     = lat_q[CI][`CNT_B_MSB:`CNT_B_LSB];
    assign aval[i]     = lat_q[CI][`CNT_A_MSB:`CNT_A_LSB];
  end

  // Two select bits come from each reference latch
  assign mux_sel = {lat_q[`DEST_L1_REF][`REF_SS_HI],
                    lat_q[`DEST_L1_REF][`REF_SS_LO],
                    lat_q[`DEST_L2_REF][`REF_SS_HI],
                    lat_q[`DEST_L2_REF][`REF_SS_LO]};
  assign crst[0] = (mux_sel == `MUX_RST2) ||
                   (mux_sel == `MUX_RSTB);
  assign crst[1] = (mux_sel == `MUX_RST1) ||
                   (mux_sel == `MUX_RSTB);
  assign fastlock = lat_q[`DEST_L1_REF][`REF_GAIN];

  // Per-loop sequencing, dividers and comparator
  for (genvar i = 0; i < 2; i++) begin : g_loop
    pd_state_t st_q, st_d;           // Power-down state
    logic      hold;                 // Dividers in load state
    rdiv_t     r_q, r_d;             // Reference count
    logic [`PRE_W-1:0] pre_q, pre_d; // Prescaler count
    logic [`PRE_W-1:0] modv;         // Current modulus
    bcnt_t     b_q, b_d;             // Main count left
    acnt_t     a_q, a_d;             // Swallow count left
    logic      rt_q, rt_d;           // Reference tick
    logic      ft_q, ft_d;           // Feedback tick
    logic      up_q, up_d;           // Up request
    logic      dn_q, dn_d;           // Down request
    logic [1:0] abl_q, abl_d;        // Overlap counter
    logic [3:0] err_q, err_d;        // One-sided run length
    logic      bad_q, bad_d;         // Wide error this period
    logic [7:0] lk_q, lk_d;          // Clean comparisons

    // Power-down sequencer next state
    always_comb begin
      st_d = st_q;
      case (st_q)
        PD_RUN: begin
          // Pump already off: go down on the loading strobe
          if (pd_bit[i]) begin
            st_d = hiz_bit[i] ? PD_DOWN : PD_PUMP_OFF;
          end
        end
        PD_PUMP_OFF: begin
          // Pump is switched off on entering this state, one cycle before down
          st_d = pd_bit[i] ? PD_DOWN : PD_RUN;
        end
        PD_DOWN: begin
          if (!pd_bit[i]) begin
            st_d = PD_RUN;
          end
        end
        default: begin
          st_d = PD_RUN; // Recover from illegal code
        end
      endcase
    end

    // Register sequencer
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        st_q <= PD_RUN;
      end else begin
        st_q <= st_d;
      end
    end

    assign pwr_dn[i] = (st_q == PD_DOWN);
    assign hold      = pwr_dn[i] | crst[i];
    assign hiz[i]    = hiz_bit[i] | crst[i] |
                       (st_q != PD_RUN);
    // Swallow cycles run at the selected modulus plus one
    assign modv = (mod_bit[i] ? `PRE_LARGE : `PRE_SMALL) +
                  ((a_q != '0) ? 7'h01 : 7'h00);

    // Divider and comparator next values
    always_comb begin
      r_d   = r_q;
      pre_d = pre_q;
      b_d   = b_q;
      a_d   = a_q;
      rt_d  = 1'b0;
      ft_d  = 1'b0;
      up_d  = up_q;
      dn_d  = dn_q;
      abl_d = abl_q;
      err_d = err_q;
      bad_d = bad_q;
      lk_d  = lk_q;
      if (hold) begin
        // Load state; both restart on the same cycle
        r_d   = '0;
        pre_d = '0;
        b_d   = bval[i];
        a_d   = aval[i];
        up_d  = 1'b0;
        dn_d  = 1'b0;
        abl_d = '0;
        err_d = '0;
        bad_d = 1'b0;
        lk_d  = '0;
      end else begin
        // Reference divider, zero treated as divide by one
        if (ps.rise[`PIN_REF]) begin
          if (r_q + 14'h0001 >= rdiv[i]) begin
            r_d  = '0;
            rt_d = 1'b1;
          end else begin
            r_d = r_q + 14'h0001;
          end
        end
        // Pulse-swallow feedback divider, N = P*B + A
        if (ps.rise[`PIN_RF2 + i]) begin
          if (pre_q + 7'h01 >= modv) begin
            pre_d = '0;
            if (a_q != '0) begin
              a_d = a_q - 6'h01;
            end
            if (b_q <= 11'h001) begin
              ft_d = 1'b1;
              b_d  = bval[i];
              a_d  = aval[i];
            end else begin
              b_d = b_q - 11'h001;
            end
          end else begin
            pre_d = pre_q + 7'h01;
          end
        end
        // Comparator: both sides fire, then clear together
        if (rt_q) begin
          up_d = 1'b1;
        end
        if (ft_q) begin
          dn_d = 1'b1;
        end
        if (up_q && dn_q) begin
          if (abl_q + 2'h1 >= ABL) begin
            up_d  = 1'b0;
            dn_d  = 1'b0;
            abl_d = '0;
          end else begin
            abl_d = abl_q + 2'h1;
          end
        end
        // Score the period at each reference tick
        if (rt_q) begin
          lk_d  = bad_q ? 8'h00 :
                  ((lk_q == LK_MAX) ? lk_q : lk_q + 8'h01);
          bad_d = 1'b0;
        end
        // A wide one-sided pulse wins over the scoring clear
        if (up_q ^ dn_q) begin
          if (err_q != 4'hF) begin
            err_d = err_q + 4'h1;
          end
          if (err_q >= `LOCK_TOL) begin
            bad_d = 1'b1;
          end
        end else begin
          err_d = '0;
        end
      end
    end

    // Register divider and comparator
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        r_q   <= '0;
        pre_q <= '0;
        b_q   <= '0;
        a_q   <= '0;
        rt_q  <= 1'b0;
        ft_q  <= 1'b0;
        up_q  <= 1'b0;
        dn_q  <= 1'b0;
        abl_q <= '0;
        err_q <= '0;
        bad_q <= 1'b0;
        lk_q  <= '0;
      end else begin
        r_q   <= r_d;
        pre_q <= pre_d;
        b_q   <= b_d;
        a_q   <= a_d;
        rt_q  <= rt_d;
        ft_q  <= ft_d;
        up_q  <= up_d;
        dn_q  <= dn_d;
        abl_q <= abl_d;
        err_q <= err_d;
        bad_q <= bad_d;
        lk_q  <= lk_d;
      end
    end

    assign locked[i] = (lk_q == LK_MAX);
    assign up[i]     = up_q;
    assign dn[i]     = dn_q;
    assign rtick[i]  = rt_q;
    assign ftick[i]  = ft_q;
  end

  // Output registers
  logic [1:0] up_o_q, up_o_d;     // Pump up pin
  logic [1:0] dn_o_q, dn_o_d;     // Pump down pin
  logic [1:0] hiz_o_q, hiz_o_d;   // Pump off pin
  logic [1:0] gain_q, gain_d;     // Pump gain pin
  logic [1:0] deb_q, deb_d;       // Input debias pin
  logic       osc_q, osc_d;       // Oscillator enable
  logic       pull_q, pull_d;     // Status pull-down
  logic       drv_q, drv_d;       // Status pin level
  logic [1:0] ld_sig;             // Lock level with pulses

  // Lock reads high, dropping during each comparator pulse
  for (genvar i = 0; i < 2; i++) begin : g_ld
    assign ld_sig[i] = locked[i] & ~(up[i] | dn[i]);
  end

  // Output next values
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      // Polarity zero swaps the pump direction
      up_o_d[k] = ~hiz[k] & (pol_bit[k] ? up[k] : dn[k]);
      dn_o_d[k] = ~hiz[k] & (pol_bit[k] ? dn[k] : up[k]);
    end
    hiz_o_d = hiz;
    gain_d  = gain_bit;
    deb_d   = pwr_dn;
    osc_d   = ~(pd_bit[0] & pd_bit[1]);
    drv_d   = 1'b0;                      // Open drain only pulls low
    // Pulled low reads as zero; released reads as pull-up high
    case (mux_sel)
      `MUX_LD2:  pull_d = ~ld_sig[0];
      `MUX_LD1:  pull_d = ~ld_sig[1];
      `MUX_LDB:  pull_d = ~(ld_sig[0] & ld_sig[1]);
      `MUX_REF2: pull_d = ~rtick[0];
      `MUX_FB2:  pull_d = ~ftick[0];
      `MUX_REF1: pull_d = ~rtick[1];
      `MUX_FB1:  pull_d = ~ftick[1];
      `MUX_LOW:  pull_d = 1'b1;
      `MUX_HIGH: pull_d = 1'b0;
      default:   pull_d = 1'b0; // Released, counter resets too
    endcase
    // Fastlock grounds the damping resistor regardless
    if (fastlock) begin
      pull_d = 1'b1;
    end
  end

  // Register outputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      up_o_q  <= '0;
      dn_o_q  <= '0;
      hiz_o_q <= 2'h3;
      gain_q  <= '0;
      deb_q   <= '0;
      osc_q   <= 1'b1;
      pull_q  <= 1'b0;
      drv_q   <= 1'b0;
    end else begin
      up_o_q  <= up_o_d;
      dn_o_q  <= dn_o_d;
      hiz_o_q <= hiz_o_d;
      gain_q  <= gain_d;
      deb_q   <= deb_d;
      osc_q   <= osc_d;
      pull_q  <= pull_d;
      drv_q   <= drv_d;
    end
  end

  assign pump_up                 = up_o_q;
  assign pump_dn                 = dn_o_q;
  assign pump_hiz                = hiz_o_q;
  assign pump_gain_hi            = gain_q;
  assign input_debias            = deb_q;
  assign ref_osc_en              = osc_q;
  assign status_select_output    = drv_q;
  assign status_select_output_oe = pull_q;
endmodule // dpll_ctrl_core

// ==== dpll_ctrl_core_asserts.sv ====
`timescale 1ns/1ns
module dpll_ctrl_core_asserts
  import dpll_pkg::*;
#(
  parameter int LOCK_CMP = 15 // Lock comparison count
) (
  input wire logic       clock,        // System clock
  input wire logic       sys_rst,      // Sync reset
  input wire logic       serial_clk,   // Serial clock pin
  input wire logic       serial_data,  // Serial data pin
  input wire logic       latch_strobe, // Latch enable pin
  input wire logic       ref_in,       // Reference pin
  input wire logic [1:0] rf_in,        // Prescaler inputs
  input wire logic [1:0] pump_up,      // Pump source
  input wire logic [1:0] pump_dn,      // Pump sink
  input wire logic [1:0] pump_hiz,     // Pump off
  input wire logic [1:0] pump_gain_hi, // Pump gain
  input wire logic [1:0] input_debias, // Loop down
  input wire logic       ref_osc_en,   // Oscillator on
  input wire logic       status_select_output,   // Pin level
  input wire logic       status_select_output_oe // Pull-down on
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Loop one entering the down state
  sequence s_down1;
    !input_debias[1] ##1 input_debias[1];
  endsequence
  // Oscillator held off for a while
  sequence s_osc_off;
    !ref_osc_en [*8];
  endsequence
  // Pump must already be off when loop one goes down
  property p_pump_first1; s_down1 |-> $past(pump_hiz[1]); endproperty
  a_pump_first1: assert property (p_pump_first1) else $error("pump on");
  // Powered-down loop two keeps its pump off
  property p_down_hiz0; input_debias[0] |-> pump_hiz[0]; endproperty
  a_down_hiz0: assert property (p_down_hiz0) else $error("pump on");
  property p_osc_off; s_osc_off |-> &input_debias; endproperty
  a_osc_off: assert property (p_osc_off) else $error("osc off");
  property p_osc_on; $rose(&input_debias) |-> !ref_osc_en; endproperty
  a_osc_on: assert property (p_osc_on) else $error("osc on");
  // Overlap lasts one cycle only, then both clear
  property p_abl0;
    pump_up[0] && pump_dn[0] |=> !pump_up[0] && !pump_dn[0];
  endproperty
  a_abl0: assert property (p_abl0) else $error("overlap");
  property p_abl1;
    pump_up[1] && pump_dn[1] |=> !(pump_up[1] || pump_dn[1]);
  endproperty
  a_abl1: assert property (p_abl1) else $error("overlap");
  // Steady fastlock pulls the status pin low
  property p_fast; pump_gain_hi[1] [*3] |-> status_select_output_oe; endproperty
  a_fast: assert property (p_fast) else $error("no fastlock");
  property p_od; !status_select_output; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
endmodule // dpll_ctrl_core_asserts
bind dpll_ctrl_core dpll_ctrl_core_asserts #(.LOCK_CMP(LOCK_CMP))
  dpll_ctrl_core_asserts_inst (.clock, .sys_rst, .serial_clk, .serial_data,
  .latch_strobe, .ref_in, .rf_in, .pump_up, .pump_dn, .pump_hiz,
  .pump_gain_hi, .input_debias, .ref_osc_en, .status_select_output,
  .status_select_output_oe);

// ==== dpll_ctrl_core_tb.sv ====
`timescale 1ns/1ns
module dpll_ctrl_core_tb
  import dpll_pkg::*;
;
  logic       clock;               // 100 MHz
  logic       sys_rst;             // Sync reset
  logic       serial_clk;          // From host
  logic       serial_data;         // From host
  logic       latch_strobe;        // From host
  logic       ref_in = 1'b0;       // Reference pin
  logic [1:0] rf_in = 2'h0;        // Prescaler pins
  logic [7:0] tick_q = 8'h00;      // Pin pattern counter
  logic [1:0] pump_up;             // Pump source
  logic [1:0] pump_dn;             // Pump sink
  logic [1:0] pump_hiz;            // Pump off
  logic [1:0] pump_gain_hi;        // Gain bits
  logic [1:0] input_debias;        // Loop down
  logic       ref_osc_en;          // Oscillator on
  logic       status_select_output;    // Pin level
  logic       status_select_output_oe; // Pull-down on
  int         err_total;           // Mismatches
  int         samples_checked;     // Comparisons
  // Observed state, oe at bit 0
  wire [7:0] obs = {pump_hiz, pump_gain_hi, input_debias, ref_osc_en,
                    status_select_output_oe};

  dpll_ctrl_core #(.LOCK_CMP(2)) dpll_ctrl_core_inst (.clock, .sys_rst,
    .serial_clk, .serial_data, .latch_strobe, .ref_in, .rf_in, .pump_up,
    .pump_dn, .pump_hiz, .pump_gain_hi, .input_debias, .ref_osc_en,
    .status_select_output, .status_select_output_oe);
  serial_host_model serial_host_model_inst (.clock, .serial_clk,
    .serial_data, .latch_strobe);

  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Reference every 256 cycles, prescaler every 8
  always @(negedge clock) begin
    tick_q <= tick_q + 8'h01;
    ref_in <= tick_q[7];
    rf_in <= {2{tick_q[2]}};
  end

  // Reference word, R=1, polarity 0
  function automatic word_t ref_w(input logic [1:0] sel, ss,
                                  input logic hiz, gain);
    return {ss, hiz, gain, 2'h0, 14'h0001, sel};
  endfunction
  // Counter word, B=1 and A=0 kept in range
  function automatic word_t cnt_w(input logic [1:0] sel,
                                  input logic pd, md);
    return {pd, md, 11'h001, 7'h00, sel};
  endfunction
  // Compare masked state
  task automatic chk(input logic [7:0] e, input string s,
                     input logic [7:0] m = 8'hFF);
    samples_checked++;
    if ((obs & m) !== (e & m)) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h", $time, s, obs);
    end
  endtask
  // One word, then let the load settle
  task automatic wr(input word_t w);
    serial_host_model_inst.send(w);
    repeat (8) @(negedge clock);
  endtask
  // Count pull-down cycles in a window
  task automatic cnt_oe(input int e);
    int n;
    n = 0;
    repeat (512) @(negedge clock) begin
      if (status_select_output_oe === 1'b1) n++;
    end
    samples_checked++;
    if (n != e) begin
      err_total++;
      $display("CHECK FAILED %0t oe count %0d", $time, n);
    end
  endtask
  // Loop-one pump activity in a window, e says any expected
  task automatic cnt_pump(input logic e);
    int n;
    n = 0;
    repeat (512) @(negedge clock) begin
      if ((pump_up[1] | pump_dn[1]) === 1'b1) n++;
    end
    samples_checked++;
    if ((n != 0) !== e) begin
      err_total++;
      $display("CHECK FAILED %0t pump count %0d", $time, n);
    end
  endtask

  task automatic test_reset;
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    chk(8'hC2, "in reset");
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    chk(8'h02, "after reset");
    $display("test_reset done");
  endtask
  // Each select reaches its own latch only
  task automatic test_load;
    wr(ref_w(2'h0, 2'h0, 1'b0, 1'b1));
    wr(cnt_w(2'h1, 1'b0, 1'b0));
    wr(ref_w(2'h2, 2'h0, 1'b0, 1'b0));
    wr(cnt_w(2'h3, 1'b0, 1'b0));
    chk(8'h12, "four loads");
    cnt_pump(1'b1);
    wr(ref_w(2'h2, 2'h0, 1'b1, 1'b0));
    chk(8'h92, "hiz one");
    cnt_pump(1'b0);
    wr(ref_w(2'h2, 2'h0, 1'b0, 1'b0));
    wr(ref_w(2'h0, 2'h0, 1'b0, 1'b0));
    chk(8'h02, "gain two clear");
    $display("test_load done");
  endtask
  // Every status code in turn
  task automatic test_status;
    logic [1:0] hz;
    for (int c = 0; c < 13; c++) begin
      wr(ref_w(2'h0, c[1:0], 1'b0, 1'b0));
      wr(ref_w(2'h2, c[3:2], 1'b0, 1'b0));
      hz = (c == 8) ? 2'h1 : (c == 9) ? 2'h2 : (c == 10) ? 2'h3 : 2'h0;
      chk({hz, 6'h02}, "status hiz", 8'hFE);
      // Tick views pull low except on the two tick cycles
      if (c inside {2, 3, 5, 6}) cnt_oe(510);
      if (c inside {0, 11}) cnt_oe(0);
      if (c == 12) cnt_oe(512);
    end
    // Larger modulus doubles the loop-two period
    wr(cnt_w(2'h1, 1'b0, 1'b1));
    wr(ref_w(2'h0, 2'h3, 1'b0, 1'b0));
    wr(ref_w(2'h2, 2'h0, 1'b0, 1'b0));
    repeat (512) @(negedge clock);
    cnt_oe(511);
    wr(cnt_w(2'h1, 1'b0, 1'b0));
    wr(ref_w(2'h0, 2'h0, 1'b0, 1'b0));
    $display("test_status done");
  endtask
  // Both power-down modes, write while down, wake
  task automatic test_pd;
    wr(ref_w(2'h2, 2'h0, 1'b1, 1'b0));
    wr(cnt_w(2'h3, 1'b1, 1'b0));
    chk(8'h8A, "async down");
    wr(cnt_w(2'h1, 1'b1, 1'b0));
    chk(8'hCC, "sync down");
    wr(ref_w(2'h0, 2'h0, 1'b0, 1'b1));
    chk(8'hDC, "write while down");
    wr(cnt_w(2'h3, 1'b0, 1'b0));
    chk(8'hD6, "loop one up");
    wr(cnt_w(2'h1, 1'b0, 1'b0));
    chk(8'h92, "loop two up");
    wr(ref_w(2'h2, 2'h0, 1'b0, 1'b0));
    wr(ref_w(2'h0, 2'h0, 1'b0, 1'b0));
    $display("test_pd done");
  endtask
  task automatic test_fast;
    wr(ref_w(2'h2, 2'h0, 1'b0, 1'b1));
    chk(8'h23, "fastlock on");
    wr(ref_w(2'h2, 2'h0, 1'b0, 1'b0));
    chk(8'h02, "fastlock off");
    $display("test_fast done");
  endtask

  // Counts, verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    test_reset();
    test_load();
    test_status();
    test_pd();
    test_fast();
    finish_test();
  end
  // Hang guard, about 50000 cycles
  initial begin
    #500000;
    err_total++;
    $display("CHECK FAILED %0t watchdog", $time);
    finish_test();
  end
endmodule // dpll_ctrl_core_tb

// ==== dpll_ctrl_regs.svh ====
`ifndef DPLL_CTRL_REGS_SVH
`define DPLL_CTRL_REGS_SVH
// Serial word and destination select
`define WORD_W      22
`define SEL_HI      1
`define SEL_LO      0
`define DEST_L2_REF 2'h0
`define DEST_L2_CNT 2'h1
`define DEST_L1_REF 2'h2
`define DEST_L1_CNT 2'h3
// Reference latch fields
`define REF_SS_HI   21
`define REF_SS_LO   20
`define REF_HIZ     19
`define REF_GAIN    18
`define REF_POL     17
`define REF_R_MSB   15
`define REF_R_LSB   2
// Counter latch fields
`define CNT_PD      21
`define CNT_MOD     20
`define CNT_B_MSB   19
`define CNT_B_LSB   9
`define CNT_A_MSB   7
`define CNT_A_LSB   2
// Divider widths and prescaler moduli
`define R_W         14
`define B_W         11
`define A_W         6
`define PRE_W       7
`define PRE_SMALL   7'h20
`define PRE_LARGE   7'h40
// Antibacklash width in ns, clock rate in MHz
`define ABL_NS      3
`define CLK_MHZ     100
`define ABL_RAW     ((`ABL_NS * `CLK_MHZ + 999) / 1000)
`define ABL_CYC     ((`ABL_RAW < 1) ? 1 : `ABL_RAW)
// Longest one-sided pump pulse still counted as locked
`define LOCK_TOL    4'h2
// Status output selections
`define MUX_W       4
`define MUX_HIZ     4'h0
`define MUX_LD2     4'h1
`define MUX_REF2    4'h2
`define MUX_FB2     4'h3
`define MUX_LD1     4'h4
`define MUX_REF1    4'h5
`define MUX_FB1     4'h6
`define MUX_LDB     4'h7
`define MUX_RST2    4'h8
`define MUX_RST1    4'h9
`define MUX_RSTB    4'hA
`define MUX_HIGH    4'hB
`define MUX_LOW     4'hC
// Synchroniser lanes
`define PIN_N       6
`define PIN_SCLK    0
`define PIN_SDATA   1
`define PIN_LE      2
`define PIN_REF     3
`define PIN_RF2     4
`endif

// ==== dpll_pkg.sv ====
`include "dpll_ctrl_regs.svh"
package dpll_pkg;
  // Power-down sequencing per loop
  typedef enum logic [1:0] {PD_RUN, PD_PUMP_OFF, PD_DOWN} pd_state_t;
  typedef logic [`WORD_W-1:0] word_t; // Serial word
  typedef logic [`R_W-1:0]    rdiv_t; // Reference divide value
  typedef logic [`B_W-1:0]    bcnt_t; // Main counter
  typedef logic [`A_W-1:0]    acnt_t; // Swallow counter
endpackage

// ==== pin_sync.sv ====
`timescale 1ns/1ns
`include "dpll_ctrl_regs.svh"
module pin_sync
  import dpll_pkg::*;
#(
  parameter int N = `PIN_N // Number of pins
) (
  input  wire logic         clock,   // System clock
  input  wire logic         sys_rst, // Sync reset, high
  input  wire logic [N-1:0] pins,    // Raw asynchronous pins
  pin_sync_if.src           ps       // Synced levels and edges
);
  // Interface width is fixed by the lane map
  if (N != `PIN_N) begin : g_bad_n
    $error("pin_sync: N must match lane count");
  end

  logic [N-1:0] s1_q, s1_d; // First stage, read only by s2
  logic [N-1:0] s2_q, s2_d; // Second stage, safe level
  logic [N-1:0] s3_q, s3_d; // Delayed copy for edges

  // Next values: plain shift chain
  always_comb begin
    s1_d = pins;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Register the chain
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign ps.level = s2_q;
  assign ps.rise  = s2_q & ~s3_q; // Edge from settled stages
endmodule // pin_sync

// ==== pin_sync_if.sv ====
`timescale 1ns/1ns
`include "dpll_ctrl_regs.svh"
interface pin_sync_if;
  logic [`PIN_N-1:0] level; // Synchronised pin levels
  logic [`PIN_N-1:0] rise;  // One-cycle rising-edge pulses
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// ==== serial_host_model.sv ====
`timescale 1ns/1ns
module serial_host_model
  import dpll_pkg::*;
(
  input  wire logic clock,        // System clock
  output logic      serial_clk,   // Idle low, still between words
  output logic      serial_data,  // Word bits
  output logic      latch_strobe  // Load pulse
);
  // Quiet link at time zero
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // Phases of 4 cycles clear the 3-cycle synchroniser
  task automatic send(input word_t w);
    for (int i = 21; i >= 0; i--) begin
      serial_data = w[i];
      repeat (4) @(negedge clock);
      serial_clk = 1'b1;
      repeat (4) @(negedge clock);
      serial_clk = 1'b0;
    end
    // Stale data flipped so a late sample cannot pass
    serial_data = ~w[0];
    repeat (4) @(negedge clock);
    latch_strobe = 1'b1;
    repeat (4) @(negedge clock);
    latch_strobe = 1'b0;
  endtask
endmodule // serial_host_model
